// ---- dma_chan_pkg.sv ----
// Purpose: shared constants and types for the four-channel transfer
//          status, flag, arbitration and channel control block
// Assumes: byte-wide register port, one system clock
// Notes:   channel registers sit in a window of eight bytes per channel
package dma_chan_pkg;

  localparam int NUM_CHAN = 4;

  // controller register offsets
  localparam logic [7:0] CTL_OFS    = 8'h00;
  localparam logic [7:0] FLAGS_OFS  = 8'h03;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] LATCH_OFS  = 8'h06;

  // channel window: addr[7:5] selects it, addr[4:3] the channel
  localparam logic [2:0] CHAN_TAG  = 3'h1;
  localparam logic [2:0] CHANNEL_CONTROL_PRIMARY_OFS = 3'h0;
  localparam logic [2:0] CHANNEL_CONTROL_SECONDARY_OFS = 3'h1;
  localparam logic [2:0] CNTL_OFS  = 3'h2;
  localparam logic [2:0] CNTH_OFS  = 3'h3;

  // controller control bits
  localparam int CC_EN  = 7;
  localparam int CC_RST = 6;

  // channel_control_primary bits
  localparam int CA_EN     = 7;
  localparam int CA_RST    = 6;
  localparam int CA_RPT    = 5;
  localparam int CA_TRIG   = 4;
  localparam int CA_SINGLE = 2;
  localparam int CA_BURST  = 0;

  // channel_control_secondary bits
  localparam int CB_FAULT = 5;
  localparam int CB_DONE  = 4;

  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] BYTES_SINGLE = 16'h0001;
  localparam logic [15:0] BYTES_DOUBLE = 16'h0002;
  localparam logic [1:0]  LEVEL_OFF   = 2'h0;
  localparam logic [1:0]  DBUF_BOTH   = 2'h3;
  localparam logic [1:0]  CHMODE_PER  = 2'h0;

  typedef enum logic [1:0] {
    ROTATE_ALL,
    FIRST_FIXED_REST_ROTATE,
    TWO_FIXED_REST_ROTATE,
    ALL_FIXED_ORDER
  } arbitration_scheme_type;

  typedef enum logic {
    ENG_IDLE,
    ENG_MOVE
  } engine_type;

endpackage

// ---- dma_chan_props.sv ----
// Purpose: port-level checks of bursts and interrupt requests
// Assumes: only the top module's ports are visible
// Notes:   requests change in the same cycle as their flag; checks still allow one cycle of lag
`timescale 1ns/1ps
`default_nettype none
module dma_chan_props (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] periph_request,
  input wire logic [3:0] eeprom_write_err,
  input wire logic [3:0] eeprom_off_err,
  input wire logic       xfer_valid,
  input wire logic [1:0] xfer_chan,
  input wire logic       xfer_last,
  input wire logic [3:0] fault_irq_req,
  input wire logic [3:0] done_irq_req,
  input wire logic [7:0] fault_irq_level,
  input wire logic [7:0] done_irq_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_last_valid: assert property (xfer_last |-> xfer_valid)
    else $error("burst end flagged without a byte");
  chk_burst_len: assert property ($rose(xfer_valid) |->
    ##[0:1] (xfer_valid && xfer_last))
    else $error("burst longer than two bytes");
  chk_burst_gap: assert property (xfer_valid && xfer_last |=>
    !xfer_valid)
    else $error("no idle cycle after a burst");
  chk_pair_chan: assert property (xfer_valid && !xfer_last |=>
    xfer_valid && xfer_last && $stable(xfer_chan))
    else $error("two-byte burst broken or channel changed");
  chk_fault_level: assert property (fault_irq_req[0] |->
    fault_irq_level[1:0] != 2'h0 || $past(fault_irq_level[1:0]) != 2'h0)
    else $error("fault request with level zero");
  chk_done_level: assert property (done_irq_req[0] |->
    done_irq_level[1:0] != 2'h0 || $past(done_irq_level[1:0]) != 2'h0)
    else $error("done request with level zero");
  chk_fault_hold: assert property (fault_irq_req[0] && !reg_wr
    && !$past(reg_wr) |=> fault_irq_req[0])
    else $error("fault request dropped without a write");
  chk_err_fault: assert property (eeprom_write_err[1]
    && fault_irq_level[3:2] != 2'h0 |-> ##[1:3] fault_irq_req[1])
    else $error("error pulse did not raise the fault request");

  cover property (xfer_valid && !xfer_last);
  cover property ($rose(fault_irq_req[1]));
  cover property ($rose(done_irq_req[0]));
endmodule // dma_chan_props

bind dma_channel_status_control dma_chan_props u_props (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .periph_request(periph_request), .eeprom_write_err(eeprom_write_err),
  .eeprom_off_err(eeprom_off_err), .xfer_valid(xfer_valid),
  .xfer_chan(xfer_chan), .xfer_last(xfer_last),
  .fault_irq_req(fault_irq_req), .done_irq_req(done_irq_req),
  .fault_irq_level(fault_irq_level), .done_irq_level(done_irq_level)
);
`default_nettype wire

// ---- dma_channel_status_control.sv ----
// Purpose: channel control, status flags, arbitration and high-byte latch
//          of a four-channel transfer controller
// Assumes: bus strobes one cycle long; read data the cycle after the strobe
// Notes:   the byte mover outside follows xfer_valid; it never stalls us
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - arbitrate four channels by scheme: rotate, 0 fixed, 0-1 fixed, all fixed.
// - channel error sets its fault flag in shared flags 7:4; write one clears.
// - channel transaction end sets done flag in shared flags 3:0; write one clears.
// - shared flags and per-channel flags are one storage, seen in both places.
// - active reads one from start until disabled, done or fault; status read-only.
// - waiting is one while a burst is pending; clears at burst start or abort.
// - reading a 16-bit low byte captures its high byte into the latch.
// - enable starts the channel; hardware clears it when the transaction ends.
// - clearing enable on a running channel stops it at burst boundary, aborts.
// - channel reset works only while disabled and clears itself afterwards.
// - repeat reloads blocks, or links partner under double buffer; locked when on.
// - software request triggers; clears at transfer start; ignored when disabled.
// - single-shot gives one burst per trigger; locked while enabled.
// - burst size select picks one or two bytes; locked while busy.
// - fault flag raises interrupt request; cleared by writing one or by a channel or controller reset.
// - done flag sets after block, or last block with repeat; write one clears.
// - fault level field enables and ranks the error interrupt request.
// - secondary bits 7 and 6 mirror channel active and waiting.
// - done level field enables and ranks the completion interrupt request.
// - errors per channel: eeprom write, eeprom off, disable during transfer.
module dma_channel_status_control (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [3:0]  periph_request,
  input  wire logic [3:0]  eeprom_write_err,
  input  wire logic [3:0]  eeprom_off_err,
  output logic             xfer_valid,
  output logic      [1:0]  xfer_chan,
  output logic             xfer_last,
  output logic      [3:0]  fault_irq_req,
  output logic      [3:0]  done_irq_req,
  output logic      [7:0]  fault_irq_level,
  output logic      [7:0]  done_irq_level
);
  import dma_chan_pkg::*;

  typedef struct packed {
    logic                   ctl_en;
    logic [1:0]             chmode;
    logic [1:0]             dbuf;
    arbitration_scheme_type arb;
    logic [7:0]             latch;
    logic [3:0]             en;
    logic [3:0]             rpt;
    logic [3:0]             trig;
    logic [3:0]             single;
    logic [3:0]             burst2;
    logic [3:0]             active;
    logic [3:0]             waiting;
    logic [3:0]             fault;
    logic [3:0]             done;
    logic [3:0]             inblk;
    logic [3:0][1:0]        flvl;
    logic [3:0][1:0]        dlvl;
    logic [3:0][15:0]       count;
    logic [3:0][15:0]       remain;
    engine_type             eng;
    logic [1:0]             bchan;
    logic                   beat;
    logic [1:0]             rr_last;
    logic [7:0]             rdata;
    logic                   xv;
    logic [1:0]             xc;
    logic                   xl;
    logic [3:0]             firq;
    logic [3:0]             dirq;
  } state_type;

  localparam state_type STATE_RESET = '0;

  logic [1:0] rst_sync_ff;
  logic       rst_n_int;
  state_type  state_ff;
  state_type  nxt_state;

  // fixed channels come first, the rest rotate after the last one served
  function automatic logic [2:0] pick(input logic [3:0] r,
                                      input logic [2:0] nfix,
                                      input logic [1:0] last);
    logic       found;
    logic [1:0] g;
    logic [1:0] c;
    found = 1'b0;
    g     = 2'h0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (!found && (3'(i) < nfix) && r[i]) begin
        found = 1'b1;
        g     = 2'(i);
      end
    end
    for (int k = 1; k <= NUM_CHAN; k++) begin
      c = 2'(int'(last) + k);
      if (!found && ({1'b0, c} >= nfix) && r[c]) begin
        found = 1'b1;
        g     = c;
      end
    end
    return {found, g};
  endfunction

  function automatic logic dbuf_on(input logic [1:0] dbuf,
                                   input logic [1:0] chmode,
                                   input logic [1:0] c);
    if (dbuf == DBUF_BOTH) begin
      return (chmode == CHMODE_PER) || !c[0];
    end
    return (dbuf[0] && !c[1]) || (dbuf[1] && c[1]);
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_ff[1];

  logic        is_chan;
  logic [1:0]  ch;
  logic [2:0]  off;
  logic [2:0]  nfix;
  logic [2:0]  choice;
  logic [3:0]  elig;
  logic [1:0]  c;
  logic [1:0]  p;
  logic [15:0] bytes;
  logic        moving;

  assign is_chan = (reg_addr[7:5] == CHAN_TAG);
  assign ch      = reg_addr[4:3];
  assign off     = reg_addr[2:0];

  always_comb begin
    nxt_state = state_ff;
    nfix   = 3'h0;
    choice = 3'h0;
    elig   = 4'h0;
    c      = state_ff.bchan;
    p      = 2'h0;
    bytes  = BYTES_SINGLE;
    moving = 1'b0;

    // register reads; data stands in the following cycle only
    nxt_state.rdata = BYTE_RESET;
    if (reg_rd) begin
      if (is_chan) begin
        unique case (off)
          CHANNEL_CONTROL_PRIMARY_OFS: nxt_state.rdata = {state_ff.en[ch], 1'b0,
                                        state_ff.rpt[ch], state_ff.trig[ch],
                                        1'b0, state_ff.single[ch], 1'b0,
                                        state_ff.burst2[ch]};
          CHANNEL_CONTROL_SECONDARY_OFS: nxt_state.rdata = {state_ff.active[ch],
                                        state_ff.waiting[ch],
                                        state_ff.fault[ch],
                                        state_ff.done[ch],
                                        state_ff.flvl[ch],
                                        state_ff.dlvl[ch]};
          CNTL_OFS: begin
            nxt_state.rdata = state_ff.count[ch][7:0];
            nxt_state.latch = state_ff.count[ch][15:8];
          end
          CNTH_OFS: nxt_state.rdata = state_ff.latch;
          default:  nxt_state.rdata = BYTE_RESET;
        endcase
      end else if (reg_addr == CTL_OFS) begin
        nxt_state.rdata = {state_ff.ctl_en, 1'b0, state_ff.chmode,
                           state_ff.dbuf, state_ff.arb};
      end else if (reg_addr == FLAGS_OFS) begin
        nxt_state.rdata = {state_ff.fault, state_ff.done};
      end else if (reg_addr == STATUS_OFS) begin
        nxt_state.rdata = {state_ff.active, state_ff.waiting};
      end else if (reg_addr == LATCH_OFS) begin
        nxt_state.rdata = state_ff.latch;
      end
    end

    // register writes; hardware sets below win over these clears
    if (reg_wr) begin
      if (is_chan && off == CHANNEL_CONTROL_PRIMARY_OFS) begin
        if (!state_ff.en[ch] && reg_wdata[CA_RST]) begin
          nxt_state.rpt[ch]     = 1'b0;
          nxt_state.trig[ch]    = 1'b0;
          nxt_state.single[ch]  = 1'b0;
          nxt_state.burst2[ch]  = 1'b0;
          nxt_state.active[ch]  = 1'b0;
          nxt_state.waiting[ch] = 1'b0;
          nxt_state.fault[ch]   = 1'b0;
          nxt_state.done[ch]    = 1'b0;
          nxt_state.inblk[ch]   = 1'b0;
          nxt_state.flvl[ch]    = LEVEL_OFF;
          nxt_state.dlvl[ch]    = LEVEL_OFF;
          nxt_state.count[ch]   = COUNT_RESET;
          nxt_state.remain[ch]  = COUNT_RESET;
        end else begin
          nxt_state.en[ch] = reg_wdata[CA_EN];
          if (!state_ff.en[ch]) begin
            nxt_state.rpt[ch]    = reg_wdata[CA_RPT];
            nxt_state.single[ch] = reg_wdata[CA_SINGLE];
          end
          if (!state_ff.active[ch]) begin
            nxt_state.burst2[ch] = reg_wdata[CA_BURST];
          end
          if (reg_wdata[CA_TRIG] && (state_ff.en[ch] || reg_wdata[CA_EN])) begin
            nxt_state.trig[ch] = 1'b1;
          end
        end
      end else if (is_chan && off == CHANNEL_CONTROL_SECONDARY_OFS) begin
        if (reg_wdata[CB_FAULT]) nxt_state.fault[ch] = 1'b0;
        if (reg_wdata[CB_DONE]) nxt_state.done[ch] = 1'b0;
        nxt_state.flvl[ch] = reg_wdata[3:2];
        nxt_state.dlvl[ch] = reg_wdata[1:0];
      end else if (is_chan && off == CNTL_OFS) begin
        if (!state_ff.en[ch]) nxt_state.count[ch] = {state_ff.latch, reg_wdata};
      end else if (is_chan && off == CNTH_OFS) begin
        nxt_state.latch = reg_wdata;
      end else if (!is_chan && reg_addr == CTL_OFS) begin
        nxt_state.ctl_en = reg_wdata[CC_EN];
        nxt_state.arb    = arbitration_scheme_type'(reg_wdata[1:0]);
        if (!state_ff.ctl_en) begin
          nxt_state.chmode = reg_wdata[5:4];
          nxt_state.dbuf   = reg_wdata[3:2];
        end
      end else if (!is_chan && reg_addr == FLAGS_OFS) begin
        nxt_state.fault = state_ff.fault & ~reg_wdata[7:4];
        nxt_state.done  = state_ff.done & ~reg_wdata[3:0];
      end else if (!is_chan && reg_addr == LATCH_OFS) begin
        nxt_state.latch = reg_wdata;
      end
    end

    // a trigger on an enabled channel makes its block pending
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (!nxt_state.en[i]) begin
        nxt_state.trig[i] = 1'b0;
      end else if (nxt_state.trig[i] || periph_request[i]) begin
        nxt_state.waiting[i] = 1'b1;
      end
    end

    // burst engine; one byte per cycle while moving
    unique case (state_ff.eng)
      ENG_IDLE: begin
        for (int i = 0; i < NUM_CHAN; i++) begin
          elig[i] = nxt_state.en[i] && state_ff.ctl_en &&
                    (nxt_state.waiting[i] ||
                     (nxt_state.inblk[i] && !nxt_state.single[i]));
        end
        nfix   = {1'b0, state_ff.arb} + 3'(state_ff.arb == ALL_FIXED_ORDER);
        choice = pick(elig, nfix, state_ff.rr_last);
        c      = choice[1:0];
        if (choice[2]) begin
          nxt_state.eng        = ENG_MOVE;
          nxt_state.bchan      = c;
          nxt_state.beat       = 1'b0;
          nxt_state.active[c]  = 1'b1;
          if ({1'b0, c} >= nfix) nxt_state.rr_last = c;
          if (nxt_state.waiting[c]) begin
            nxt_state.waiting[c] = 1'b0;
            nxt_state.trig[c]    = 1'b0;
          end
          if (!nxt_state.inblk[c]) begin
            nxt_state.inblk[c]  = 1'b1;
            nxt_state.remain[c] = state_ff.count[c];
          end
        end
      end
      ENG_MOVE: begin
        bytes = state_ff.burst2[c] ? BYTES_DOUBLE : BYTES_SINGLE;
        p = (state_ff.dbuf == DBUF_BOTH && state_ff.chmode != CHMODE_PER) ?
            (c ^ 2'h2) : (c ^ 2'h1);
        if (state_ff.beat != state_ff.burst2[c]) begin
          nxt_state.beat = 1'b1;
        end else begin
          nxt_state.eng = ENG_IDLE;
          if (!nxt_state.en[c] || !state_ff.ctl_en) begin
            // stop only at the burst edge so no half word is left behind
            nxt_state.en[c]      = 1'b0;
            nxt_state.fault[c]   = 1'b1;
            nxt_state.active[c]  = 1'b0;
            nxt_state.waiting[c] = 1'b0;
            nxt_state.inblk[c]   = 1'b0;
            nxt_state.trig[c]    = 1'b0;
          end else if (state_ff.remain[c] <= bytes) begin
            if (state_ff.rpt[c] &&
                !dbuf_on(state_ff.dbuf, state_ff.chmode, c)) begin
              nxt_state.remain[c] = state_ff.count[c];
            end else begin
              nxt_state.inblk[c]  = 1'b0;
              nxt_state.en[c]     = 1'b0;
              nxt_state.active[c] = 1'b0;
              nxt_state.done[c]   = 1'b1;
              if (dbuf_on(state_ff.dbuf, state_ff.chmode, c)) begin
                nxt_state.rpt[c] = 1'b0;
                if (nxt_state.rpt[p]) begin
                  nxt_state.en[p]  = 1'b1;
                  nxt_state.rpt[p] = 1'b0;
                end
              end
            end
          end else begin
            nxt_state.remain[c] = state_ff.remain[c] - bytes;
          end
        end
      end
    endcase

    // channels switched off drop pending work and fault if busy; with the
    // controller off, idle channels keep their enable and pending request
    for (int i = 0; i < NUM_CHAN; i++) begin
      moving = (nxt_state.eng == ENG_MOVE) && (nxt_state.bchan == 2'(i));
      if (!moving && (!nxt_state.en[i] ||
                      (!state_ff.ctl_en && nxt_state.active[i]))) begin
        if (nxt_state.active[i]) nxt_state.fault[i] = 1'b1;
        nxt_state.en[i]      = 1'b0;
        nxt_state.active[i]  = 1'b0;
        nxt_state.waiting[i] = 1'b0;
        nxt_state.inblk[i]   = 1'b0;
      end
    end

    // memory faults reported by the mover kill the channel at once
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (eeprom_write_err[i] || eeprom_off_err[i]) begin
        nxt_state.fault[i]   = 1'b1;
        nxt_state.en[i]      = 1'b0;
        nxt_state.active[i]  = 1'b0;
        nxt_state.waiting[i] = 1'b0;
        nxt_state.inblk[i]   = 1'b0;
        nxt_state.trig[i]    = 1'b0;
        if (nxt_state.eng == ENG_MOVE && nxt_state.bchan == 2'(i)) begin
          nxt_state.eng = ENG_IDLE;
        end
      end
    end

    // controller reset only while the controller is off
    if (reg_wr && !is_chan && reg_addr == CTL_OFS &&
        !state_ff.ctl_en && reg_wdata[CC_RST]) begin
      nxt_state = STATE_RESET;
    end

    // registered outputs track the next state so they align with it
    nxt_state.xv = (nxt_state.eng == ENG_MOVE);
    nxt_state.xc = nxt_state.bchan;
    nxt_state.xl = nxt_state.xv &&
                   (nxt_state.beat == nxt_state.burst2[nxt_state.bchan]);
    for (int i = 0; i < NUM_CHAN; i++) begin
      nxt_state.firq[i] = nxt_state.fault[i] &&
                          (nxt_state.flvl[i] != LEVEL_OFF);
      nxt_state.dirq[i] = nxt_state.done[i] &&
                          (nxt_state.dlvl[i] != LEVEL_OFF);
    end
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state_ff <= STATE_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata       = state_ff.rdata;
  assign xfer_valid      = state_ff.xv;
  assign xfer_chan       = state_ff.xc;
  assign xfer_last       = state_ff.xl;
  assign fault_irq_req   = state_ff.firq;
  assign done_irq_req    = state_ff.dirq;
  assign fault_irq_level = state_ff.flvl;
  assign done_irq_level  = state_ff.dlvl;

endmodule // dma_channel_status_control

`default_nettype wire

// ---- mover_model.sv ----
// Purpose: byte mover stand-in; counts moved bytes, logs granted channels
// Assumes: one byte per xfer_valid cycle, the mover never stalls
// Notes:   raises one error pulse on an armed channel when asked
`timescale 1ns/1ps
`default_nettype none
module mover_model (
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic        xfer_valid,
  input  wire logic [1:0]  xfer_chan,
  input  wire logic        err_arm,
  input  wire logic [1:0]  err_chan,
  input  wire logic        err_kind,
  output logic      [3:0]  eeprom_write_err,
  output logic      [3:0]  eeprom_off_err,
  output logic      [7:0]  byte_total,
  output logic      [13:0] chan_log
);
  logic fired_ff;
  always_ff @(posedge clk or posedge clr) begin
    if (clr) begin
      eeprom_write_err <= 4'h0;
      eeprom_off_err   <= 4'h0;
      byte_total       <= 8'h00;
      chan_log         <= 14'h0000;
      fired_ff         <= 1'b0;
    end else begin
      eeprom_write_err <= 4'h0;
      eeprom_off_err   <= 4'h0;
      if (xfer_valid) begin
        byte_total <= byte_total + 8'h01;
        chan_log   <= {chan_log[11:0], xfer_chan};
        // one fault until the next clr, raised mid-block to reach the abort path
        if (err_arm && !fired_ff && xfer_chan == err_chan) begin
          fired_ff <= 1'b1;
          if (err_kind) begin
            eeprom_off_err[err_chan] <= 1'b1;
          end else begin
            eeprom_write_err[err_chan] <= 1'b1;
          end
        end
      end
    end
  end
endmodule // mover_model
`default_nettype wire

// ---- testbench.sv ----
// Purpose: register-level tests of the four-channel transfer controller
// Assumes: read data sampled in the cycle after the strobe
// Notes:   every access ends with one spare edge so strobes never merge
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dma_chan_pkg::*;
  logic        clk, rst_n, reg_wr, reg_rd, clr, err_arm, err_kind;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, byte_total;
  logic [7:0]  fault_irq_level, done_irq_level;
  logic [3:0]  periph_request, eeprom_write_err, eeprom_off_err;
  logic [3:0]  fault_irq_req, done_irq_req;
  logic [1:0]  xfer_chan, err_chan;
  logic        xfer_valid, xfer_last;
  logic [13:0] chan_log;
  logic [13:0] arb_exp [4] = '{14'h1b18, 14'h01b6, 14'h016e, 14'h016b};
  logic [7:0]  zero_regs [7] = '{8'h00, 8'h03, 8'h04, 8'h06, 8'h20,
                                 8'h21, 8'h10};
  int          err_total, samples_checked, cycles;

  dma_channel_status_control uut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .periph_request(periph_request), .eeprom_write_err(eeprom_write_err),
    .eeprom_off_err(eeprom_off_err), .xfer_valid(xfer_valid),
    .xfer_chan(xfer_chan), .xfer_last(xfer_last),
    .fault_irq_req(fault_irq_req), .done_irq_req(done_irq_req),
    .fault_irq_level(fault_irq_level), .done_irq_level(done_irq_level));

  mover_model mover (
    .clk(clk), .clr(clr), .xfer_valid(xfer_valid), .xfer_chan(xfer_chan),
    .err_arm(err_arm), .err_chan(err_chan), .err_kind(err_kind),
    .eeprom_write_err(eeprom_write_err), .eeprom_off_err(eeprom_off_err),
    .byte_total(byte_total), .chan_log(chan_log));

  function automatic logic [7:0] ca(input int n, input logic [2:0] o);
    return {CHAN_TAG, n[1:0], o};
  endfunction

  task automatic give_verdict;
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
    chk({8'h00, d}, {8'h00, e});
  endtask

  task automatic setcnt(input int n, input logic [7:0] lo);
    wr(ca(n, CNTH_OFS), 8'h00);
    wr(ca(n, CNTL_OFS), lo);
  endtask

  task automatic clear_log;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    @(posedge clk);
  endtask

  // bounded wait on the mover's byte count, then let the flags settle
  task automatic wait_bytes(input logic [7:0] n);
    int k;
    k = 0;
    while (byte_total !== n && k < 200) begin
      @(posedge clk);
      k++;
    end
    repeat (3) @(posedge clk);
    chk({8'h00, byte_total}, {8'h00, n});
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    int i;
    rst_n = 1'b0;
    {reg_wr, reg_rd, err_arm, err_kind} = 4'h0;
    clr = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    periph_request = 4'h0;
    err_chan = 2'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    clr   <= 1'b0;
    repeat (3) @(posedge clk);
    // reset values, one unmapped address, status write ignored
    for (i = 0; i < 7; i++) rc(zero_regs[i], 8'h00);
    wr(STATUS_OFS, 8'hff);
    rc(STATUS_OFS, 8'h00);
    wr(ca(0, CNTH_OFS), 8'h12);
    wr(ca(0, CNTL_OFS), 8'h34);
    wr(LATCH_OFS, 8'h00);
    rc(ca(0, CNTL_OFS), 8'h34);
    rc(LATCH_OFS, 8'h12);
    wr(LATCH_OFS, 8'ha5);
    rc(LATCH_OFS, 8'ha5);
    wr(ca(1, CHANNEL_CONTROL_PRIMARY_OFS), 8'h05);
    rc(ca(1, CHANNEL_CONTROL_PRIMARY_OFS), 8'h05);
    wr(ca(1, CHANNEL_CONTROL_PRIMARY_OFS), 8'h40);
    rc(ca(1, CHANNEL_CONTROL_PRIMARY_OFS), 8'h00);
    // one-byte block by software request
    wr(CTL_OFS, 8'h80);
    setcnt(0, 8'h01);
    wr(ca(0, CHANNEL_CONTROL_SECONDARY_OFS), 8'h05);
    clear_log();
    wr(ca(0, CHANNEL_CONTROL_PRIMARY_OFS), 8'h90);
    wait_bytes(8'h01);
    rc(FLAGS_OFS, 8'h01);
    rc(ca(0, CHANNEL_CONTROL_SECONDARY_OFS), 8'h15);
    rc(ca(0, CHANNEL_CONTROL_PRIMARY_OFS), 8'h00);
    rc(STATUS_OFS, 8'h00);
    chk({12'h000, done_irq_req}, 16'h0001);
    chk({fault_irq_level, done_irq_level}, 16'h0101);
    wr(ca(0, CHANNEL_CONTROL_SECONDARY_OFS), 8'h15);
    rc(FLAGS_OFS, 8'h00);
    // two-byte bursts over a four-byte block
    setcnt(0, 8'h04);
    clear_log();
    wr(ca(0, CHANNEL_CONTROL_PRIMARY_OFS), 8'h91);
    wait_bytes(8'h04);
    rc(FLAGS_OFS, 8'h01);
    wr(FLAGS_OFS, 8'h01);
    // single shot, locked bits, then abort by disable
    setcnt(0, 8'h04);
    wr(ca(0, CHANNEL_CONTROL_PRIMARY_OFS), 8'h04);
    clear_log();
    wr(ca(0, CHANNEL_CONTROL_PRIMARY_OFS), 8'h94);
    wait_bytes(8'h01);
    rc(ca(0, CHANNEL_CONTROL_PRIMARY_OFS), 8'h84);
    rc(STATUS_OFS, 8'h10);
    wr(ca(0, CHANNEL_CONTROL_PRIMARY_OFS), 8'he0);
    rc(ca(0, CHANNEL_CONTROL_PRIMARY_OFS), 8'h84);
    chk({8'h00, byte_total}, 16'h0001);
    wr(ca(0, CHANNEL_CONTROL_PRIMARY_OFS), 8'h00);
    rc(FLAGS_OFS, 8'h10);
    rc(STATUS_OFS, 8'h00);
    chk({12'h000, fault_irq_req}, 16'h0001);
    wr(FLAGS_OFS, 8'h10);
    rc(FLAGS_OFS, 8'h00);
    // mover errors: write fault on channel 1, sleep fault on channel 2
    for (i = 1; i < 3; i++) begin
      setcnt(i, 8'h04);
      wr(ca(i, CHANNEL_CONTROL_SECONDARY_OFS), 8'h04);
      clear_log();
      err_chan <= 2'(i);
      err_kind <= i[1];
      err_arm  <= 1'b1;
      wr(ca(i, CHANNEL_CONTROL_PRIMARY_OFS), 8'h90);
      repeat (6) @(posedge clk);
      rc(FLAGS_OFS, 8'h10 << i);
      rc(STATUS_OFS, 8'h00);
      err_arm <= 1'b0;
      wr(FLAGS_OFS, 8'h10 << i);
    end
    // pending requests, then each arbitration scheme
    for (i = 0; i < 4; i++) begin
      // controller off, then reset, so every rotation starts alike
      wr(CTL_OFS, 8'h00);
      wr(CTL_OFS, 8'h40);
      for (int c = 0; c < 4; c++) begin
        setcnt(c, (c < 3) ? 8'h02 : 8'h01);
        wr(ca(c, CHANNEL_CONTROL_PRIMARY_OFS), 8'h80);
      end
      clear_log();
      periph_request <= 4'hf;
      @(posedge clk);
      periph_request <= 4'h0;
      rc(STATUS_OFS, 8'h0f);
      rc(ca(3, CHANNEL_CONTROL_SECONDARY_OFS), 8'h40);
      wr(CTL_OFS, 8'h80 | 8'(i));
      wait_bytes(8'h07);
      chk({2'h0, chan_log}, {2'h0, arb_exp[i]});
      rc(FLAGS_OFS, 8'h0f);
    end
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
